// ===== fbi_regs.svh
// constants for the flash burst bus interface: widths, burst length and timing counts
// assumes a 250 MHz core clock (4 ns period); times are in ns
`ifndef FBI_REGS_SVH
`define FBI_REGS_SVH
`define FBI_ADDR_W          19
`define FBI_DATA_W          16
`define FBI_BURST_LEN       32
`define FBI_BURST_CNT_W     5
`define FBI_BURST_LAST      5'h1f
`define FBI_CLK_PERIOD_NS   4
`define FBI_INIT_ACCESS_NS  65
`define FBI_BURST_ACCESS_NS 17
// longest times round down, never below one cycle
`define FBI_INIT_ACCESS_CYC  ((`FBI_INIT_ACCESS_NS / `FBI_CLK_PERIOD_NS) < 1 ? 1 : (`FBI_INIT_ACCESS_NS / `FBI_CLK_PERIOD_NS))
`define FBI_BURST_ACCESS_CYC ((`FBI_BURST_ACCESS_NS / `FBI_CLK_PERIOD_NS) < 1 ? 1 : (`FBI_BURST_ACCESS_NS / `FBI_CLK_PERIOD_NS))
// command codes for burst mode enable/disable, written with address 0
`define FBI_CMD_BURST_EN    16'h00a0
`define FBI_CMD_BURST_DIS   16'h00a1
`endif

// ===== fbi_pkg.sv
// types shared by the flash burst bus interface
// assumes fbi_regs.svh supplies the numeric constants
package fbi_pkg;
  typedef enum logic [1:0] {
    FBI_ASYNC,   // conventional array read mode
    FBI_IDLE,    // burst mode, no burst loaded
    FBI_WAIT,    // initial or burst access delay running
    FBI_VALID    // word valid and held
  } fbi_state_t;
endpackage

// ===== fbi_sync2.sv
// two-flop synchroniser for a bus of pin inputs
// assumes the inputs are asynchronous to clock_i
`timescale 1ns/100ps
module fbi_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;  // first stage, read only by the second stage

  // two stages; the enable freezes both
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else if (clk_en_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule // fbi_sync2

// ===== fbi_cmd_latch.sv
// command latch: captures address and data of each host write
// assumes synchronised, active-low strobes; emits a one-cycle command pulse
`timescale 1ns/100ps
`include "fbi_regs.svh"
module fbi_cmd_latch (
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   write_n_i,
  input  wire logic                   chip_sel_n_i,
  input  wire logic                   out_en_n_i,
  input  wire logic [`FBI_ADDR_W-1:0] addr_i,
  input  wire logic [`FBI_DATA_W-1:0] data_i,
  output logic      [`FBI_ADDR_W-1:0] cmd_addr_o,
  output logic      [`FBI_DATA_W-1:0] cmd_data_o,
  output logic                        cmd_valid_o
);
  logic wr_active;  // write cycle in progress
  logic wr_prev;    // previous write state, for the end-of-write edge

  assign wr_active = !write_n_i && !chip_sel_n_i && out_en_n_i;

  // latch address/data while write is active; it is not an addressable location
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_addr_o <= '0;
      cmd_data_o <= '0;
    end else if (clk_en_i && wr_active) begin
      cmd_addr_o <= addr_i;
      cmd_data_o <= data_i;
    end
  end

  // command is handed on at the rising end of the write strobe
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_prev     <= 1'b0;
      cmd_valid_o <= 1'b0;
    end else if (clk_en_i) begin
      wr_prev     <= wr_active;
      cmd_valid_o <= wr_prev && !wr_active;
    end else begin
      cmd_valid_o <= 1'b0;
    end
  end
endmodule // fbi_cmd_latch

// ===== fbi_burst_port.sv
// flash burst bus interface, device side: async read, command writes and the
// linear 32-word burst read engine with load, advance, suspend and wrap
// assumes clock_i is the burst clock at 250 MHz; all pins are synchronised here;
// the array itself is outside and answers array_addr_o with array_data_i next cycle
`timescale 1ns/100ps
`include "fbi_regs.svh"

module fbi_burst_port
  import fbi_pkg::*;
#(
  parameter int INIT_CYC  = `FBI_INIT_ACCESS_CYC,   // initial access delay in cycles
  parameter int BURST_CYC = `FBI_BURST_ACCESS_CYC   // burst access delay in cycles
) (
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   clk_en_i,
  // pins from the host
  input  wire logic [`FBI_ADDR_W-1:0] word_address_i,
  input  wire logic [`FBI_DATA_W-1:0] data_bus_i,
  output logic      [`FBI_DATA_W-1:0] data_bus_o,
  output logic                        data_bus_oe_n_o,
  input  wire logic                   chip_sel_n_i,
  input  wire logic                   out_en_n_i,
  input  wire logic                   write_en_n_i,
  input  wire logic                   hw_reset_n_i,
  input  wire logic                   burst_start_load_n_i,
  input  wire logic                   burst_step_n_i,
  output logic                        last_word_flag_n_o,
  // array side
  output logic      [`FBI_ADDR_W-1:0] array_addr_o,
  input  wire logic [`FBI_DATA_W-1:0] array_data_i,
  // latched command for the internal state machine
  output logic      [`FBI_ADDR_W-1:0] cmd_addr_o,
  output logic      [`FBI_DATA_W-1:0] cmd_data_o,
  output logic                        cmd_valid_o,
  output logic                        burst_mode_o
);

  localparam int CW = `FBI_BURST_CNT_W;
  // the array answers two edges after the state moves: one for array_addr_o, one
  // for the array's own register; the wait counts them so a short delay never
  // lets a stale word become valid
  localparam int PIPE_CYC = 2;
  localparam int SYNC_W = 2 + `FBI_ADDR_W + `FBI_DATA_W + 4;

  initial begin
    if (INIT_CYC < 1 || INIT_CYC > 253 || BURST_CYC < 1 || BURST_CYC > 253)
      $error("access delays must lie in 1..253 cycles");
  end

  // synchronised pins
  logic [`FBI_ADDR_W-1:0] addr_s;        // word address
  logic [`FBI_DATA_W-1:0] wdata_s;       // write data
  logic                   cs_n_s;        // chip select
  logic                   oe_n_s;        // output enable
  logic                   we_n_s;        // write enable
  logic                   rst_n_s;       // hardware reset pin
  logic                   load_n_s;      // burst start load
  logic                   step_n_s;      // burst step

  // burst engine state
  fbi_state_t             state_reg;     // burst engine state
  logic                   burst_mode_reg;// burst mode enabled by command
  logic [`FBI_ADDR_W-1:0] start_reg;     // burst start word address
  logic [CW-1:0]          count_reg;     // offset from start, wraps at 32
  logic [7:0]             delay_reg;     // access delay countdown
  logic [`FBI_DATA_W-1:0] word_reg;      // word held for output
  logic                   word_ok_reg;   // word_reg holds a valid word
  logic                   load_evt;      // load taken this edge
  logic                   step_evt;      // step taken this edge

  // all host pins are asynchronous to clock_i, enables included
  fbi_sync2 #(
    .WIDTH   (SYNC_W),
    .RST_VAL ({2'b11, {(`FBI_ADDR_W + `FBI_DATA_W){1'b0}}, 4'hf})
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({chip_sel_n_i, out_en_n_i, word_address_i, data_bus_i,
                 write_en_n_i, hw_reset_n_i, burst_start_load_n_i, burst_step_n_i}),
    .sync_o    ({cs_n_s, oe_n_s, addr_s, wdata_s, we_n_s, rst_n_s, load_n_s, step_n_s})
  );

  // command writes latched off the address space
  fbi_cmd_latch u_cmd (
    .clock_i      (clock_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .write_n_i    (we_n_s),
    .chip_sel_n_i (cs_n_s),
    .out_en_n_i   (oe_n_s),
    .addr_i       (addr_s),
    .data_i       (wdata_s),
    .cmd_addr_o   (cmd_addr_o),
    .cmd_data_o   (cmd_data_o),
    .cmd_valid_o  (cmd_valid_o)
  );

  // load only with select low, write high and advance high
  assign load_evt = burst_mode_reg && !cs_n_s && we_n_s && !load_n_s && step_n_s;
  // step needs select low and load high; output enable gates only the bus and command writes
  assign step_evt = burst_mode_reg && !cs_n_s && we_n_s && load_n_s && !step_n_s
                    && (state_reg == FBI_VALID);

  // burst mode flag: set and cleared by commands, dropped by the reset pin
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      burst_mode_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!rst_n_s) begin
        burst_mode_reg <= 1'b0;
      end else if (cmd_valid_o && cmd_data_o == `FBI_CMD_BURST_EN) begin
        burst_mode_reg <= 1'b1;
      end else if (cmd_valid_o && cmd_data_o == `FBI_CMD_BURST_DIS) begin
        burst_mode_reg <= 1'b0;
      end
    end
  end

  // burst engine: load, step with wrap, access delays, terminate
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= FBI_ASYNC;
      start_reg <= '0;
      count_reg <= '0;
      delay_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (!rst_n_s || !burst_mode_reg) begin
        state_reg <= FBI_ASYNC;  // clock, load and advance ignored here
        count_reg <= '0;
      end else if (cs_n_s) begin
        state_reg <= FBI_IDLE;   // select high ends the burst
      end else if (load_evt) begin
        start_reg <= addr_s;
        count_reg <= '0;
        delay_reg <= 8'(INIT_CYC + PIPE_CYC);  // delay plus array pipeline
        state_reg <= FBI_WAIT;
      end else if (step_evt) begin
        count_reg <= count_reg + 1'b1;  // 5-bit counter wraps 31 -> 0
        delay_reg <= 8'(BURST_CYC + PIPE_CYC);  // delay plus array pipeline
        state_reg <= FBI_WAIT;
      end else begin
        case (state_reg)
          FBI_ASYNC: state_reg <= FBI_IDLE;
          FBI_IDLE:  state_reg <= FBI_IDLE;
          FBI_WAIT: begin
            if (delay_reg <= 8'h01) state_reg <= FBI_VALID;
            delay_reg <= delay_reg - 8'h01;
          end
          FBI_VALID: state_reg <= FBI_VALID;  // no step: hold or suspend
          default:   state_reg <= FBI_IDLE;
        endcase
      end
    end
  end

  // array address: burst position in WAIT and VALID, pins in ASYNC and IDLE
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      array_addr_o <= '0;
    end else if (clk_en_i) begin
      if (state_reg == FBI_ASYNC || state_reg == FBI_IDLE)
        array_addr_o <= addr_s;
      else  // upper bits stay with the start word; low five bits wrap
        array_addr_o <= {start_reg[`FBI_ADDR_W-1:CW], CW'(start_reg[CW-1:0] + count_reg)};
    end
  end

  // output word: tracks the array in async mode, frozen once a burst word is valid
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_reg    <= '0;
      word_ok_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (state_reg == FBI_ASYNC) begin
        word_reg    <= array_data_i;
        word_ok_reg <= 1'b1;
      end else if (state_reg == FBI_WAIT) begin
        word_reg    <= array_data_i;  // settles before the delay ends
        word_ok_reg <= 1'b0;
      end else if (state_reg == FBI_VALID) begin
        word_ok_reg <= 1'b1;          // held through suspend
      end else begin
        word_ok_reg <= 1'b0;
      end
    end
  end

  // data bus drive and last-word flag
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      data_bus_o         <= '0;
      data_bus_oe_n_o    <= 1'b1;
      last_word_flag_n_o <= 1'b1;
    end else if (clk_en_i) begin
      data_bus_o <= word_reg;  // all 16 lines
      // float on reset, select high, output enable high or write
      data_bus_oe_n_o <= !rst_n_s || cs_n_s || oe_n_s || !we_n_s || !word_ok_reg;
      last_word_flag_n_o <= !(state_reg == FBI_VALID && count_reg == `FBI_BURST_LAST);
    end
  end

  assign burst_mode_o = burst_mode_reg;

endmodule // fbi_burst_port

// ===== fbi_array_model.sv
// array stand-in behind the burst port: one word per address, one cycle late
// assumes the port samples array_data_i the cycle after it sets array_addr_o
`timescale 1ns/100ps
`include "fbi_regs.svh"
module fbi_array_model (
  input  wire logic                   clock_i,
  input  wire logic [`FBI_ADDR_W-1:0] addr_i,
  output logic      [`FBI_DATA_W-1:0] data_o
);
  // top address bits fold into the word so that a wrong upper half is seen
  always_ff @(posedge clock_i) begin
    data_o <= addr_i[15:0] ^ {addr_i[18:16], 13'h1a3c};
  end
endmodule // fbi_array_model

// ===== fbi_port_assertions.sv
// checker for the burst port pins: floating, hold, command and mode relations
// assumes bind from the bench; every pin passes two sync flops first
`timescale 1ns/100ps
`include "fbi_regs.svh"
module fbi_port_assertions #(
  parameter int INIT_CYC = `FBI_INIT_ACCESS_CYC  // initial access delay in cycles
) (
  input wire logic                   clock_i,
  input wire logic                   sys_rst_i,
  input wire logic                   chip_sel_n_i,
  input wire logic                   out_en_n_i,
  input wire logic                   write_en_n_i,
  input wire logic                   hw_reset_n_i,
  input wire logic                   burst_start_load_n_i,
  input wire logic                   burst_step_n_i,
  input wire logic [`FBI_DATA_W-1:0] data_bus_o,
  input wire logic                   data_bus_oe_n_o,
  input wire logic                   last_word_flag_n_o,
  input wire logic                   cmd_valid_o,
  input wire logic                   burst_mode_o
);
  localparam int HOLD = INIT_CYC + 8;  // margin for sync, access wait and array cycle
  logic [3:0] oe_hist;    // recent output enable samples
  logic [3:0] cs_hist;    // recent chip select samples
  logic [3:0] rst_hist;   // recent reset pin samples
  logic [4:0] quiet_cnt;  // driven burst cycles with no load, step or deselect
  // four samples cover both sync flops and the output register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_hist  <= 4'h0;
      cs_hist  <= 4'h0;
      rst_hist <= 4'hf;
    end else begin
      oe_hist  <= {oe_hist[2:0], out_en_n_i};
      cs_hist  <= {cs_hist[2:0], chip_sel_n_i};
      rst_hist <= {rst_hist[2:0], hw_reset_n_i};
    end
  end
  // saturating, so a long hold never wraps back into the settle window
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quiet_cnt <= 5'h00;
    end else if (!burst_step_n_i || !burst_start_load_n_i || chip_sel_n_i || data_bus_oe_n_o || !burst_mode_o) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1f) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  oe_float_a: assert property (out_en_n_i && &oe_hist |-> data_bus_oe_n_o)
    else $error("bus driven with output enable high");
  cs_float_a: assert property (chip_sel_n_i && &cs_hist |-> data_bus_oe_n_o)
    else $error("bus driven with chip select high");
  hwrst_float_a: assert property (!hw_reset_n_i && rst_hist == 4'h0 |-> data_bus_oe_n_o)
    else $error("bus driven during reset pin");
  hwrst_mode_a: assert property (!hw_reset_n_i && rst_hist == 4'h0 |-> !burst_mode_o)
    else $error("burst mode kept during reset pin");
  word_hold_a: assert property (quiet_cnt > HOLD |-> $stable(data_bus_o))
    else $error("word changed without step");
  cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse longer than one cycle");
  cmd_after_write_a: assert property ($rose(write_en_n_i) && !chip_sel_n_i && out_en_n_i |-> ##[2:8] cmd_valid_o)
    else $error("write not latched");
  flag_mode_a: assert property (!last_word_flag_n_o |-> burst_mode_o)
    else $error("last word flag outside burst mode");
  cover property (!last_word_flag_n_o);
  cover property ($rose(burst_mode_o));
  cover property ($fell(data_bus_oe_n_o));
endmodule // fbi_port_assertions

// ===== flash_burst_bus_interface_bench.sv
// bench for the burst port: async read, commands, burst, suspend, restart, reset
// assumes one-cycle access parameters; the array model answers a cycle late
`timescale 1ns/100ps
`include "fbi_regs.svh"
module flash_burst_bus_interface_bench;
  logic        clock_i = 1'b0, sys_rst_i = 1'b1;  // clock and reset
  logic        cs_n = 1'b1, oe_n = 1'b1, we_n = 1'b1;  // host strobes
  logic        hrst_n = 1'b1, ld_n = 1'b1, st_n = 1'b1;  // reset, load, step pins
  logic [18:0] addr = 19'h0, arr_a, cmd_a, s;  // addresses
  logic [15:0] wdata = 16'h0, dout, arr_d, cmd_d;  // data
  logic        dout_oe_n, flag_n, cmd_v, bmode;  // design flags
  int          err_total = 0, check_count = 0, cyc = 0;
  `define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
  always #2 clock_i = ~clock_i;
  fbi_burst_port #(.INIT_CYC(1), .BURST_CYC(1)) uut (.clock_i, .sys_rst_i, .clk_en_i(1'b1),
    .word_address_i(addr), .data_bus_i(wdata), .data_bus_o(dout), .data_bus_oe_n_o(dout_oe_n),
    .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_en_n_i(we_n), .hw_reset_n_i(hrst_n),
    .burst_start_load_n_i(ld_n), .burst_step_n_i(st_n), .last_word_flag_n_o(flag_n),
    .array_addr_o(arr_a), .array_data_i(arr_d), .cmd_addr_o(cmd_a), .cmd_data_o(cmd_d),
    .cmd_valid_o(cmd_v), .burst_mode_o(bmode));
  fbi_array_model arr (.clock_i, .addr_i(arr_a), .data_o(arr_d));
  function automatic logic [15:0] word_of(input logic [18:0] a);
    return a[15:0] ^ {a[18:16], 13'h1a3c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // look at the bus mid-cycle, where registered outputs have settled
  task automatic chk_out(input logic [15:0] w, input logic oe_exp);
    @(negedge clock_i);
    `CHK("data_bus_oe_n_o", oe_exp, dout_oe_n)
    if (!oe_exp) `CHK("data_bus_o", w, dout)
  endtask
  // write cycle, then wait a bounded time for the latched command
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    oe_n <= 1'b1;
    cs_n <= 1'b0;
    we_n <= 1'b0;
    tick(4);
    we_n <= 1'b1;
    do @(negedge clock_i); while (cmd_v !== 1'b1 && ++n < 12);
    `CHK("cmd_addr_o", a, cmd_a)
    `CHK("cmd_data_o", d, cmd_d)
    tick(4);
    cs_n <= 1'b1;
  endtask
  // load pulse of one clock, then the pins go invalid while load is high
  task automatic ld(input logic [18:0] a);
    @(posedge clock_i);
    addr <= a;
    cs_n <= 1'b0;
    ld_n <= 1'b0;
    @(posedge clock_i);
    ld_n <= 1'b1;
    addr <= ~a;
    tick(12);
  endtask
  task automatic step;
    @(posedge clock_i);
    st_n <= 1'b0;
    @(posedge clock_i);
    st_n <= 1'b1;
    tick(12);
  endtask
  task automatic sc_async;
    @(posedge clock_i);
    addr <= 19'h4_1234;
    cs_n <= 1'b0;
    oe_n <= 1'b0;
    ld_n <= 1'b0;
    st_n <= 1'b0;
    tick(12);
    chk_out(word_of(19'h4_1234), 1'b0);
    `CHK("burst_mode_o", 1'b0, bmode)
    @(posedge clock_i);
    ld_n <= 1'b1;
    st_n <= 1'b1;
    cs_n <= 1'b1;
    tick(6);
    chk_out(16'h0, 1'b1);
  endtask
  task automatic sc_burst;
    wr(19'h0, `FBI_CMD_BURST_EN);
    `CHK("burst_mode_o", 1'b1, bmode)
    s = 19'h5_27da;
    @(posedge clock_i);
    oe_n <= 1'b0;
    ld(s);
    chk_out(word_of(s), 1'b0);
    for (int i = 1; i <= 32; i++) begin
      step();
      chk_out(word_of({s[18:5], s[4:0] + 5'(i)}), 1'b0);
      `CHK("last_word_flag_n_o", (i == 31) ? 1'b0 : 1'b1, flag_n)
    end
  endtask
  task automatic sc_suspend;
    @(posedge clock_i);
    oe_n <= 1'b1;
    tick(8);
    chk_out(16'h0, 1'b1);
    @(posedge clock_i);
    oe_n <= 1'b0;
    tick(8);
    chk_out(word_of(s), 1'b0);
    @(posedge clock_i);
    oe_n <= 1'b1;
    step();
    chk_out(16'h0, 1'b1);
    @(posedge clock_i);
    oe_n <= 1'b0;
    step();
    chk_out(word_of({s[18:5], s[4:0] + 5'h2}), 1'b0);
  endtask
  task automatic sc_restart;
    ld(19'h2_0003);
    chk_out(word_of(19'h2_0003), 1'b0);
    @(posedge clock_i);
    cs_n <= 1'b1;
    tick(8);
    chk_out(16'h0, 1'b1);
    wr(19'h0, `FBI_CMD_BURST_DIS);
    `CHK("burst_mode_o", 1'b0, bmode)
    wr(19'h0, `FBI_CMD_BURST_EN);
    ld(19'h1_0010);
    hrst_n <= 1'b0;
    tick(8);
    chk_out(16'h0, 1'b1);
    `CHK("burst_mode_o", 1'b0, bmode)
    @(posedge clock_i);
    hrst_n <= 1'b1;
  endtask
  task automatic conclude;
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cycle ceiling well above the several hundred the scenarios need
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 6000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    tick(2);
    sys_rst_i <= 1'b0;
    tick(3);
    sc_async();
    sc_burst();
    sc_suspend();
    sc_restart();
    tick(4);
    conclude();
  end
endmodule // flash_burst_bus_interface_bench
bind fbi_burst_port fbi_port_assertions #(.INIT_CYC(INIT_CYC)) chk (.clock_i, .sys_rst_i, .chip_sel_n_i,
  .out_en_n_i, .write_en_n_i, .hw_reset_n_i, .burst_start_load_n_i, .burst_step_n_i, .data_bus_o,
  .data_bus_oe_n_o, .last_word_flag_n_o, .cmd_valid_o, .burst_mode_o);
